// ==== verilog/lpmc_pkg.sv ====
// Constants for the low-power mode controller: register map, field positions, reset values.
// Assumes a single bus clock domain and a plain strobe register port.
// Functional notes
// RULE1: STOP gates oscillator, halting timer, serial, converter.
// RULE2: Leave STOP only on external interrupt or reset.
// RULE3: Entering STOP clears global interrupt mask.
// RULE4: Entering STOP clears slow-mode select bit.
// RULE5: Wake vector: interrupt pair or reset pair.
// RULE6: Hold CPU for 16 or 4064 settle cycles.
// RULE7: After settling, service interrupt or fetch reset.
// RULE8: Interrupt stacking only after leaving STOP.
// RULE9: STOP resets watchdog, freezes peripherals, memory read-only.
// RULE10: STOP leaves all other state unaltered.
// RULE11: WAIT halts CPU, peripherals keep running.
// RULE12: WAIT watchdog follows its mask option.
// RULE13: Entering WAIT clears mask, keeps interrupt enable.
// RULE14: WAIT exits on external, timer, serial interrupt, reset.
// RULE15: Interrupt exit keeps state; reset exit resets all.
// RULE16: Timer always runs during WAIT.
// RULE17: Slow mode adds divide-by-16 before bus clock.
// RULE18: Slow-mode select is bit 1 at 000C.
// RULE19: External or power-on reset clears slow-mode select.
// RULE20: Software avoids slow mode during conversion or programming.
// RULE21: Two bits choose trigger; enable bit gates it.
// RULE22: Trigger writes need mask set; change clears pending.
// RULE23: Internal reset drives reset pin low, open drain.
package lpmc_pkg;
	localparam logic [7:0] MISC_CONTROL_ADDR = 8'h0C;
	localparam int SLOW_MODE_BIT = 1;
	localparam int IRQ_ENABLE_BIT = 4;
	localparam int IRQ_NEG_BIT = 5;
	localparam int IRQ_POS_BIT = 6;
	localparam int WATCHDOG_CTL_BIT_BIT = 0;
	localparam int POR_BIT = 7;
	localparam logic [7:0] MISC_RESET = 8'h10;
	localparam logic [15:0] VEC_IRQ = 16'h1FFA;
	localparam logic [15:0] VEC_RESET = 16'h1FFE;
	localparam int SETTLE_SHORT = 16;
	localparam int SETTLE_LONG = 4064;
	localparam int SLOW_DIV = 16;
	localparam int SLOW_DIV_W = 4;
	localparam int SETTLE_W = 12;
	typedef enum logic [3:0]
	{
		ST_RUN = 4'b0001,
		ST_WAIT = 4'b0010,
		ST_STOP = 4'b0100,
		ST_SETTLE = 4'b1000
	} lpmc_state_t;
endpackage

// ==== verilog/lpmc_ctrl.sv ====
// Low-power mode controller: STOP, WAIT, SLOW, external interrupt trigger and reset pin drive.
// Assumes the CPU core pulses stop_req or wait_req for one cycle on the instruction and
// treats cpu_hold as a stall; peripherals obey osc_run and bus_tick.
//
// Strobed register access was left to the implementer.
module lpmc_ctrl
	import lpmc_pkg::*;
#(
	parameter bit LONG_SETTLE = 1'b1,
	parameter bit WAIT_WATCHDOG_CTL_BIT_EN = 1'b0
)
(
	input wire logic clk,
	input wire logic srst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic stop_req,
	input wire logic wait_req,
	input wire logic cpu_imask,
	output logic imask_clr,
	input wire logic irq_pin_n,
	input wire logic periph_irq,
	input wire logic rst_pin_in,
	output logic rst_pin_out,
	output logic rst_pin_oe_n,
	input wire logic internal_rst,
	input wire logic por_flag,
	output logic osc_run,
	output logic bus_tick,
	output logic cpu_hold,
	output logic watchdog_clear,
	output logic watchdog_run,
	output logic nvm_read_only,
	output logic irq_pending,
	output logic wake_valid,
	output logic [15:0] wake_vector,
	output logic stack_enable
);
	localparam logic [SETTLE_W-1:0] SETTLE_CNT =
		LONG_SETTLE ? SETTLE_W'(SETTLE_LONG - 1) : SETTLE_W'(SETTLE_SHORT - 1);
	localparam logic [SLOW_DIV_W-1:0] DIV_MAX = SLOW_DIV_W'(SLOW_DIV - 1);

	lpmc_state_t state_q;
	logic [SETTLE_W-1:0] settle_q;
	logic slow_q, ipos_q, ineg_q, ien_q, watchdog_ctl_bit_q;
	logic [SLOW_DIV_W-1:0] div_q;
	logic irq_s1_q, irq_s2_q, irq_prev_q;
	logic rst_s1_q, rst_s2_q;
	logic irq_pend_q;
	logic wake_rst_q;
	logic rdv_q;
	logic [7:0] rdata_q;
	logic wr_misc, trig_change, irq_edge, irq_level, irq_event, pin_rst;

	assign wr_misc = reg_wr && reg_addr == MISC_CONTROL_ADDR;
	// Trigger bits only accept writes while the CPU mask is set.
	assign trig_change = wr_misc && cpu_imask && // RULE22
		(reg_wdata[IRQ_POS_BIT] != ipos_q || reg_wdata[IRQ_NEG_BIT] != ineg_q);
	assign pin_rst = !rst_s2_q;
	// Four trigger options: low level, neg edge, pos edge, both edges.
	assign irq_edge = (ineg_q && irq_prev_q && !irq_s2_q) || // RULE21
		(ipos_q && !irq_prev_q && irq_s2_q);
	assign irq_level = !ipos_q && !ineg_q && !irq_s2_q;
	assign irq_event = ien_q && (irq_edge || irq_level); // RULE21

	always_ff @(posedge clk)
	begin
		irq_s1_q <= irq_pin_n;
		irq_s2_q <= irq_s1_q;
		rst_s1_q <= rst_pin_in;
		rst_s2_q <= rst_s1_q;
		if (srst)
			irq_prev_q <= 1'b1;
		else
			irq_prev_q <= irq_s2_q;
	end

	// Pending external interrupt; a set in the same cycle wins over a trigger-change clear.
	always_ff @(posedge clk)
	begin
		if (srst || pin_rst)
			irq_pend_q <= 1'b0;
		else if (irq_event)
			irq_pend_q <= 1'b1;
		else if (trig_change || (state_q == ST_SETTLE && settle_q == '0 && !wake_rst_q))
			irq_pend_q <= 1'b0; // RULE22
	end

	// Control register; reset clears slow mode, entering STOP clears it too.
	always_ff @(posedge clk)
	begin
		if (srst || pin_rst)
		begin
			slow_q <= 1'b0; // RULE19
			ipos_q <= MISC_RESET[IRQ_POS_BIT];
			ineg_q <= MISC_RESET[IRQ_NEG_BIT];
			ien_q <= MISC_RESET[IRQ_ENABLE_BIT];
			watchdog_ctl_bit_q <= MISC_RESET[WATCHDOG_CTL_BIT_BIT];
		end
		else
		begin
			if (stop_req && state_q == ST_RUN)
				slow_q <= 1'b0; // RULE4
			else if (wr_misc)
				slow_q <= reg_wdata[SLOW_MODE_BIT]; // RULE18
			if (wr_misc)
			begin
				ien_q <= reg_wdata[IRQ_ENABLE_BIT];
				watchdog_ctl_bit_q <= watchdog_ctl_bit_q | reg_wdata[WATCHDOG_CTL_BIT_BIT];
				if (cpu_imask)
				begin
					ipos_q <= reg_wdata[IRQ_POS_BIT]; // RULE22
					ineg_q <= reg_wdata[IRQ_NEG_BIT];
				end
			end
		end
	end

	// Mode sequencer. STOP entry clears slow_q, interrupt exit clears irq_pend_q and STOP holds div_q at zero; other registers are untouched.
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state_q <= ST_RUN;
			settle_q <= '0;
			wake_rst_q <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				ST_RUN:
				begin
					if (stop_req)
						state_q <= ST_STOP; // RULE1 RULE10
					else if (wait_req)
						state_q <= ST_WAIT; // RULE11
				end
				ST_WAIT:
				begin
					if (pin_rst)
						state_q <= ST_RUN; // RULE15
					else if (irq_pend_q || periph_irq)
						state_q <= ST_RUN; // RULE14 RULE15
				end
				ST_STOP:
				begin
					if (pin_rst || irq_pend_q)
					begin
						state_q <= ST_SETTLE; // RULE2
						settle_q <= SETTLE_CNT; // RULE6
						wake_rst_q <= pin_rst;
					end
				end
				ST_SETTLE:
				begin
					if (pin_rst)
						wake_rst_q <= 1'b1;
					if (settle_q == '0)
						state_q <= ST_RUN; // RULE7
					else
						settle_q <= settle_q - 1'b1;
				end
			endcase
		end
	end

	// Bus clock divider; slow mode adds a divide-by-16, STOP clears it to zero.
	always_ff @(posedge clk)
	begin
		if (srst || state_q == ST_STOP)
			div_q <= '0;
		else if (!slow_q || div_q == DIV_MAX)
			div_q <= '0; // RULE17
		else
			div_q <= div_q + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			rdv_q <= 1'b0;
			rdata_q <= 8'h00;
		end
		else
		begin
			rdv_q <= reg_rd;
			if (reg_rd)
				rdata_q <= (reg_addr == MISC_CONTROL_ADDR) ?
					{por_flag, ipos_q, ineg_q, ien_q, 2'b00, slow_q, watchdog_ctl_bit_q} : 8'h00;
		end
	end

	assign reg_rdata = rdv_q ? rdata_q : 8'h00;
	assign imask_clr = (state_q == ST_RUN) && (stop_req || wait_req); // RULE3 RULE13
	assign osc_run = state_q != ST_STOP; // RULE1
	assign bus_tick = osc_run && state_q != ST_SETTLE && (!slow_q || div_q == DIV_MAX); // RULE16
	assign cpu_hold = state_q != ST_RUN; // RULE6 RULE11
	assign watchdog_clear = state_q == ST_STOP; // RULE9
	assign watchdog_run = state_q == ST_RUN || (state_q == ST_WAIT && WAIT_WATCHDOG_CTL_BIT_EN); // RULE12
	assign nvm_read_only = state_q == ST_STOP; // RULE9
	assign irq_pending = irq_pend_q;
	assign wake_valid = state_q == ST_SETTLE && settle_q == '0; // RULE7
	assign wake_vector = wake_rst_q ? VEC_RESET : VEC_IRQ; // RULE5
	assign stack_enable = state_q == ST_RUN || wake_valid; // RULE8
	assign rst_pin_out = 1'b0;
	assign rst_pin_oe_n = !internal_rst; // RULE23
endmodule

// ==== tb/lpmc_cpu_model.sv ====
// CPU core stand-in: raises STOP and WAIT requests and keeps the I-bit.
// Assumes the bench raises one of go_stop, go_wait, set_mask or clr_mask for one cycle.
module lpmc_cpu_model
(
	input wire logic clk,
	input wire logic srst,
	input wire logic go_stop,
	input wire logic go_wait,
	input wire logic set_mask,
	input wire logic clr_mask,
	input wire logic imask_clr,
	input wire logic cpu_hold,
	output logic stop_req,
	output logic wait_req,
	output logic cpu_imask
);
	// A stalled core executes no instruction, so no request leaves it.
	assign stop_req = go_stop && !cpu_hold;
	assign wait_req = go_wait && !cpu_hold;
	always_ff @(posedge clk)
	begin
		if (srst || set_mask)
			cpu_imask <= 1'b1;
		else if (imask_clr || clr_mask)
			cpu_imask <= 1'b0;
	end
endmodule

// ==== tb/lpmc_assertions.sv ====
// Port checker for the low-power mode controller.
// Assumes one clock domain with synchronous reset srst.
module lpmc_chk
	import lpmc_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic stop_req,
	input wire logic wait_req,
	input wire logic imask_clr,
	input wire logic internal_rst,
	input wire logic rst_pin_out,
	input wire logic rst_pin_oe_n,
	input wire logic osc_run,
	input wire logic cpu_hold,
	input wire logic watchdog_clear,
	input wire logic nvm_read_only,
	input wire logic wake_valid,
	input wire logic [15:0] wake_vector,
	input wire logic stack_enable
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	sequence s_stop;
		stop_req && !cpu_hold;
	endsequence
	sequence s_wait;
		wait_req && !cpu_hold;
	endsequence
	chk_stop_mask: assert property (s_stop |-> imask_clr)
		else $error("stop left mask set");
	chk_stop_osc: assert property (s_stop |=> !osc_run && cpu_hold)
		else $error("stop kept oscillator");
	chk_wait_mask: assert property (s_wait |-> imask_clr)
		else $error("wait left mask set");
	chk_wait_run: assert property (s_wait |=> cpu_hold && osc_run)
		else $error("wait state wrong");
	chk_stop_side: assert property (!osc_run |-> nvm_read_only && watchdog_clear)
		else $error("stop side effects missing");
	chk_settle_hold: assert property ($rose(osc_run) |-> cpu_hold [*8])
		else $error("cpu released early");
	chk_stack_late: assert property (stack_enable |-> osc_run)
		else $error("stacking while stopped");
	chk_wake_vec: assert property (wake_valid |-> wake_vector == VEC_IRQ
		|| wake_vector == VEC_RESET)
		else $error("bad wake vector");
	chk_rst_drive: assert property (internal_rst |-> ##[0:2] !rst_pin_oe_n && !rst_pin_out)
		else $error("reset pin not driven");
endmodule
bind lpmc_ctrl lpmc_chk u_lpmc_chk (.clk, .srst, .stop_req, .wait_req, .imask_clr,
	.internal_rst, .rst_pin_out, .rst_pin_oe_n, .osc_run, .cpu_hold, .watchdog_clear,
	.nvm_read_only, .wake_valid, .wake_vector, .stack_enable);

// ==== tb/tb_top.sv ====
// Self-checking bench for the low-power mode controller and a CPU stand-in.
// Assumes a 50 MHz clock and the short settle option to keep the run brief.
module tb_top
	import lpmc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, srst, reg_wr, reg_rd, irq_pin_n, periph_irq, internal_rst, por_flag;
	logic stop_req, wait_req, cpu_imask, imask_clr, rst_pin_out, rst_pin_oe_n, osc_run;
	logic bus_tick, cpu_hold, watchdog_clear, watchdog_run, nvm_read_only, irq_pending;
	logic wake_valid, stack_enable;
	logic [3:0] cmd;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
	logic [15:0] wake_vector;
	int n_mismatch, n_checks, k;
	// The reset pin has a pull-up; the controller can only pull it low.
	wire rst_lvl = rst_pin_oe_n | rst_pin_out;
	lpmc_cpu_model u_lpmc_cpu_model (.clk, .srst, .go_stop(cmd[0]), .go_wait(cmd[1]),
		.set_mask(cmd[2]), .clr_mask(cmd[3]), .imask_clr, .cpu_hold, .stop_req, .wait_req,
		.cpu_imask);
	lpmc_ctrl #(.LONG_SETTLE(1'b0), .WAIT_WATCHDOG_CTL_BIT_EN(1'b0)) u_lpmc_ctrl (.clk, .srst,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .stop_req, .wait_req, .cpu_imask,
		.imask_clr, .irq_pin_n, .periph_irq, .rst_pin_in(rst_lvl), .rst_pin_out, .rst_pin_oe_n,
		.internal_rst, .por_flag, .osc_run, .bus_tick, .cpu_hold, .watchdog_clear,
		.watchdog_run, .nvm_read_only, .irq_pending, .wake_valid, .wake_vector, .stack_enable);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic flag(input logic got, input logic exp);
		chk({15'h0000, got}, {15'h0000, exp});
	endtask
	task automatic wr(input logic [7:0] d);
		@(posedge clk);
		reg_addr <= MISC_CONTROL_ADDR;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask
	task automatic pulse(input int i);
		@(posedge clk);
		cmd[i] <= 1'b1;
		@(posedge clk);
		cmd <= 4'h0;
		#1;
	endtask
	task automatic wait_for(input int n);
		k = 0;
		while (wake_valid !== 1'b1 && cpu_hold !== 1'b0 && k < n)
		begin
			@(posedge clk);
			#1 k++;
		end
	endtask
	task automatic t_regs;
		rd(MISC_CONTROL_ADDR);
		chk({8'h00, rd_val}, {8'h00, MISC_RESET});
		rd(8'h0D);
		chk({8'h00, rd_val}, 16'h0000);
		wr(8'h72);
		rd(MISC_CONTROL_ADDR);
		chk({8'h00, rd_val}, 16'h0072);
		pulse(3);
		wr(8'h12);
		rd(MISC_CONTROL_ADDR);
		chk({8'h00, rd_val}, 16'h0072);
		k = 0;
		repeat (32)
		begin
			@(posedge clk);
			#1 k += int'(bus_tick);
		end
		chk(16'(k), 16'(32 / SLOW_DIV));
	endtask
	task automatic t_stop;
		pulse(2);
		pulse(0);
		flag(cpu_imask, 1'b0);
		flag(osc_run, 1'b0);
		repeat (40) @(posedge clk);
		#1 flag(cpu_hold, 1'b1);
		irq_pin_n <= 1'b0;
		wait_for(100);
		flag(wake_valid, 1'b1);
		flag(k >= SETTLE_SHORT, 1'b1);
		chk(wake_vector, VEC_IRQ);
		irq_pin_n <= 1'b1;
		rd(MISC_CONTROL_ADDR);
		flag(rd_val[SLOW_MODE_BIT], 1'b0);
	endtask
	task automatic t_wait;
		pulse(2);
		wr(8'h52);
		#1 flag(irq_pending, 1'b0);
		pulse(1);
		flag(cpu_hold, 1'b1);
		flag(osc_run, 1'b1);
		periph_irq <= 1'b1;
		wait_for(20);
		flag(cpu_hold, 1'b0);
		periph_irq <= 1'b0;
		rd(MISC_CONTROL_ADDR);
		flag(rd_val[IRQ_ENABLE_BIT], 1'b1);
	endtask
	task automatic t_intrst;
		wr(8'h12);
		internal_rst <= 1'b1;
		repeat (3) @(posedge clk);
		#1 flag(rst_pin_oe_n, 1'b0);
		internal_rst <= 1'b0;
		repeat (4) @(posedge clk);
		rd(MISC_CONTROL_ADDR);
		chk({8'h00, rd_val}, {8'h00, MISC_RESET});
	endtask
	task automatic summarize;
		$display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial
	begin
		#100us;
		n_mismatch++;
		summarize();
	end
	initial
	begin
		{srst, reg_wr, reg_rd, periph_irq, internal_rst, por_flag} = 6'b100000;
		{irq_pin_n, cmd, reg_addr, reg_wdata} = {1'b1, 4'h0, 16'h0000};
		n_mismatch = 0;
		n_checks = 0;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		t_regs();
		t_stop();
		t_wait();
		t_intrst();
		summarize();
	end
endmodule
